// >>> hbd_debug_unit.sv
// Debug unit: entry capture, cause recording, stop mask, scratch and breakpoints
`timescale 1ns/10ps
`include "hbd_defines.svh"

// How it works
// - On debug entry the interrupted program counter is captured into saved_pc.
// - On debug entry the interrupted stack pointer is captured into saved_stack_ptr.
// - Register-read target: 8-bit thread and 5-bit register fields, written in debug mode.
// - Cause code: 1 host, 2 debug call, 3 insn break, 4 data, 5 resource.
// - Breakpoint index field is zero for host/debug call; lowest index wins.
// - Causing thread number is recorded; zero for host requests.
// - Info register takes memory address on data hit, resource id on resource hit.
// - Threads set in the stop mask never run outside debug mode.
// - Eight scratch words shared between debug bus and tile configuration port.
// - Four instruction breakpoints compare the program counter with their own address.
// - Instruction breakpoint condition bit: 0 break on equal, 1 on unequal.
// - Each breakpoint control word has an 8-bit per-thread enable mask.
// - A breakpoint acts only while its control bit 0 is set; controls reset zero.
// - Four data watchpoints, each with address A and address B registers.
// - Data watchpoint condition bit: 0 means A AND B, 1 means A OR B.
// - Data watchpoint load bit lets load operations trigger it.
// - Four resource watchpoints, each with a mask and a value register.
// - Resource watchpoint condition bit: 0 fires on masked value equal, 1 on unequal.
module hbd_debug_unit
   import hbd_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Debug register port
   input wire logic [`HBD_ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Tile configuration view of the scratch words
   input wire logic [2:0] cfg_scr_addr_i,
   input wire logic [31:0] cfg_scr_wdata_i,
   input wire logic cfg_scr_wr_i,
   input wire logic cfg_scr_rd_i,
   output logic [31:0] cfg_scr_rdata_o,
   // Processor observation
   input wire hbd_op_t insn_op_i,
   input wire hbd_op_t mem_op_i,
   input wire hbd_op_t res_op_i,
   input wire logic host_dbg_req_i,
   input wire logic debug_call_insn_i,
   input wire logic [2:0] debug_call_thread_i,
   input wire logic [31:0] ctx_pc_i,
   input wire logic [31:0] ctx_sp_i,
   input wire logic dbg_return_i,
   // Status towards the processor
   output logic dbg_mode_o,
   output logic dbg_enter_o,
   output logic [7:0] thread_stop_o,
   output logic [7:0] regread_thread_o,
   output logic [4:0] regread_reg_o
);

   localparam int NBP = `HBD_NUM_BP;

   ////////////////////////////////////////////////////////////////////////////////
   // State
   hbd_mode_t mode_r, mode_nxt;
   logic enter_r, enter_nxt;
   logic [7:0] stop_out_r, stop_out_nxt;
   logic [31:0] saved_pc_r, saved_pc_nxt;
   logic [31:0] saved_sp_r, saved_sp_nxt;
   logic [31:0] rr_thread_r, rr_thread_nxt;
   logic [31:0] rr_reg_r, rr_reg_nxt;
   logic [31:0] cause_r, cause_nxt;
   logic [31:0] info_r, info_nxt;
   logic [31:0] stop_mask_r, stop_mask_nxt;
   logic [31:0] scratch_r [`HBD_NUM_SCR];
   logic [31:0] scratch_nxt [`HBD_NUM_SCR];
   logic [31:0] ib_addr_r [NBP];
   logic [31:0] ib_addr_nxt [NBP];
   logic [31:0] ib_ctl_r [NBP];
   logic [31:0] ib_ctl_nxt [NBP];
   logic [31:0] dw_a_r [NBP];
   logic [31:0] dw_a_nxt [NBP];
   logic [31:0] dw_b_r [NBP];
   logic [31:0] dw_b_nxt [NBP];
   logic [31:0] dw_ctl_r [NBP];
   logic [31:0] dw_ctl_nxt [NBP];
   logic [31:0] rw_mask_r [NBP];
   logic [31:0] rw_mask_nxt [NBP];
   logic [31:0] rw_val_r [NBP];
   logic [31:0] rw_val_nxt [NBP];
   logic [31:0] rw_ctl_r [NBP];
   logic [31:0] rw_ctl_nxt [NBP];
   logic [31:0] rdata_r, rdata_nxt;
   logic [31:0] cfg_rdata_r, cfg_rdata_nxt;

   logic [NBP-1:0] ib_hit;
   logic [NBP-1:0] dw_hit;
   logic [NBP-1:0] rw_hit;
   hbd_entry_t entry;
   logic entry_req;

   ////////////////////////////////////////////////////////////////////////////////
   // Breakpoint and watchpoint matching, one copy per entry
   genvar g;
   generate
      for (g = 0; g < NBP; g++)
      begin : g_bp
         logic ib_eq;
         logic dw_ca;
         logic dw_cb;
         logic dw_cond;
         logic rw_eq;
         logic rw_cond;

         assign ib_eq = (insn_op_i.value == ib_addr_r[g]);
         assign ib_hit[g] = insn_op_i.valid
            && ib_ctl_r[g][`HBD_CTL_EN_BIT]
            && ib_ctl_r[g][`HBD_CTL_THR_LSB + insn_op_i.thread]
            && (ib_ctl_r[g][`HBD_CTL_COND_BIT] ? !ib_eq : ib_eq);

         // Condition A is the lower bound, B the upper: AND gives a window
         assign dw_ca = (mem_op_i.value >= dw_a_r[g]);
         assign dw_cb = (mem_op_i.value <= dw_b_r[g]);
         assign dw_cond = dw_ctl_r[g][`HBD_CTL_COND_BIT] ? (dw_ca || dw_cb)
                                                         : (dw_ca && dw_cb);
         assign dw_hit[g] = mem_op_i.valid && dw_cond
            && dw_ctl_r[g][`HBD_CTL_EN_BIT]
            && dw_ctl_r[g][`HBD_CTL_THR_LSB + mem_op_i.thread]
            && (!mem_op_i.is_load || dw_ctl_r[g][`HBD_CTL_LOAD_BIT]);

         assign rw_eq = ((res_op_i.value & rw_mask_r[g]) == rw_val_r[g]);
         assign rw_cond = rw_ctl_r[g][`HBD_CTL_COND_BIT] ? !rw_eq : rw_eq;
         assign rw_hit[g] = res_op_i.valid && rw_cond
            && rw_ctl_r[g][`HBD_CTL_EN_BIT]
            && rw_ctl_r[g][`HBD_CTL_THR_LSB + res_op_i.thread];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Debug entry arbitration: host, debug call, insn, data, resource
   always_comb
   begin
      entry = '0;
      entry_req = 1'b1;
      if (host_dbg_req_i)
      begin
         entry.code = `HBD_CAUSE_HOST;
         entry.thread = 8'h00;
         entry.index = 2'h0;
      end
      else if (debug_call_insn_i)
      begin
         entry.code = `HBD_CAUSE_DEBUG_CALL_INSN;
         entry.thread = {5'h00, debug_call_thread_i};
         entry.index = 2'h0;
      end
      else if (|ib_hit)
      begin
         entry.code = `HBD_CAUSE_IBREAK;
         entry.thread = {5'h00, insn_op_i.thread};
         for (int i = NBP - 1; i >= 0; i--)
            if (ib_hit[i])
               entry.index = 2'(i);
      end
      else if (|dw_hit)
      begin
         entry.code = `HBD_CAUSE_DWATCH;
         entry.thread = {5'h00, mem_op_i.thread};
         entry.load_info = 1'b1;
         entry.info = mem_op_i.value;
         for (int i = NBP - 1; i >= 0; i--)
            if (dw_hit[i])
               entry.index = 2'(i);
      end
      else if (|rw_hit)
      begin
         entry.code = `HBD_CAUSE_RWATCH;
         entry.thread = {5'h00, res_op_i.thread};
         entry.load_info = 1'b1;
         entry.info = res_op_i.value;
         for (int i = NBP - 1; i >= 0; i--)
            if (rw_hit[i])
               entry.index = 2'(i);
      end
      else
      begin
         entry_req = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state: mode, registers written by software or by debug entry
   always_comb
   begin
      logic dbg_wr;
      dbg_wr = reg_wr_i && (mode_r == HBD_DEBUG);
      mode_nxt = mode_r;
      enter_nxt = 1'b0;
      saved_pc_nxt = saved_pc_r;
      saved_sp_nxt = saved_sp_r;
      rr_thread_nxt = rr_thread_r;
      rr_reg_nxt = rr_reg_r;
      cause_nxt = cause_r;
      info_nxt = info_r;
      stop_mask_nxt = stop_mask_r;
      scratch_nxt = scratch_r;
      ib_addr_nxt = ib_addr_r;
      ib_ctl_nxt = ib_ctl_r;
      dw_a_nxt = dw_a_r;
      dw_b_nxt = dw_b_r;
      dw_ctl_nxt = dw_ctl_r;
      rw_mask_nxt = rw_mask_r;
      rw_val_nxt = rw_val_r;
      rw_ctl_nxt = rw_ctl_r;

      // Tile configuration writes go first so a debug write in the same cycle wins
      if (cfg_scr_wr_i)
         scratch_nxt[cfg_scr_addr_i] = cfg_scr_wdata_i;

      // Debug-mode-only writes; in run mode they are dropped silently
      if (dbg_wr)
      begin
         case (reg_addr_i)
            `HBD_IDX_SAVED_PC: saved_pc_nxt = reg_wdata_i;
            `HBD_IDX_SAVED_SP: saved_sp_nxt = reg_wdata_i;
            `HBD_IDX_RR_THREAD: rr_thread_nxt = reg_wdata_i & `HBD_RR_THREAD_MASK;
            `HBD_IDX_RR_REG: rr_reg_nxt = reg_wdata_i & `HBD_RR_REG_MASK;
            `HBD_IDX_CAUSE: cause_nxt = reg_wdata_i & `HBD_CAUSE_MASK;
            `HBD_IDX_INFO: info_nxt = reg_wdata_i;
            `HBD_IDX_STOP_MASK: stop_mask_nxt = reg_wdata_i & `HBD_STOP_MASK_MASK;
            default:
            begin
               for (int i = 0; i < `HBD_NUM_SCR; i++)
                  if (reg_addr_i == `HBD_IDX_SCRATCH + 8'(i))
                     scratch_nxt[i] = reg_wdata_i;
               for (int i = 0; i < NBP; i++)
               begin
                  if (reg_addr_i == `HBD_IDX_IB_ADDR + 8'(i))
                     ib_addr_nxt[i] = reg_wdata_i;
                  if (reg_addr_i == `HBD_IDX_IB_CTL + 8'(i))
                     ib_ctl_nxt[i] = reg_wdata_i & `HBD_IB_CTL_MASK;
                  if (reg_addr_i == `HBD_IDX_DW_ADDR_A + 8'(i))
                     dw_a_nxt[i] = reg_wdata_i;
                  if (reg_addr_i == `HBD_IDX_DW_ADDR_B + 8'(i))
                     dw_b_nxt[i] = reg_wdata_i;
                  if (reg_addr_i == `HBD_IDX_DW_CTL + 8'(i))
                     dw_ctl_nxt[i] = reg_wdata_i & `HBD_DW_CTL_MASK;
                  if (reg_addr_i == `HBD_IDX_RW_MASK + 8'(i))
                     rw_mask_nxt[i] = reg_wdata_i;
                  if (reg_addr_i == `HBD_IDX_RW_VALUE + 8'(i))
                     rw_val_nxt[i] = reg_wdata_i;
                  if (reg_addr_i == `HBD_IDX_RW_CTL + 8'(i))
                     rw_ctl_nxt[i] = reg_wdata_i & `HBD_RW_CTL_MASK;
               end
            end
         endcase
      end

      case (mode_r)
         HBD_RUN:
         begin
            // Entry capture overrides any software write in the same cycle
            if (entry_req)
            begin
               mode_nxt = HBD_DEBUG;
               enter_nxt = 1'b1;
               saved_pc_nxt = ctx_pc_i;
               saved_sp_nxt = ctx_sp_i;
               cause_nxt = {14'h0000, entry.index, entry.thread, 5'h00, entry.code};
               if (entry.load_info)
                  info_nxt = entry.info;
            end
         end
         HBD_DEBUG:
         begin
            // Events seen while in debug mode are not recorded
            if (dbg_return_i)
               mode_nxt = HBD_RUN;
         end
         default: mode_nxt = HBD_RUN;
      endcase

      // Debug mode halts every user thread; outside it the mask holds its threads
      stop_out_nxt = (mode_nxt == HBD_DEBUG) ? 8'hFF : stop_mask_nxt[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   always_comb
   begin
      rdata_nxt = `HBD_RESET_WORD;
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            `HBD_IDX_SAVED_PC: rdata_nxt = saved_pc_r;
            `HBD_IDX_SAVED_SP: rdata_nxt = saved_sp_r;
            `HBD_IDX_RR_THREAD: rdata_nxt = rr_thread_r;
            `HBD_IDX_RR_REG: rdata_nxt = rr_reg_r;
            `HBD_IDX_CAUSE: rdata_nxt = cause_r;
            `HBD_IDX_INFO: rdata_nxt = info_r;
            `HBD_IDX_STOP_MASK: rdata_nxt = stop_mask_r;
            default:
            begin
               for (int i = 0; i < `HBD_NUM_SCR; i++)
                  if (reg_addr_i == `HBD_IDX_SCRATCH + 8'(i))
                     rdata_nxt = scratch_r[i];
               for (int i = 0; i < NBP; i++)
               begin
                  if (reg_addr_i == `HBD_IDX_IB_ADDR + 8'(i))
                     rdata_nxt = ib_addr_r[i];
                  if (reg_addr_i == `HBD_IDX_IB_CTL + 8'(i))
                     rdata_nxt = ib_ctl_r[i];
                  if (reg_addr_i == `HBD_IDX_DW_ADDR_A + 8'(i))
                     rdata_nxt = dw_a_r[i];
                  if (reg_addr_i == `HBD_IDX_DW_ADDR_B + 8'(i))
                     rdata_nxt = dw_b_r[i];
                  if (reg_addr_i == `HBD_IDX_DW_CTL + 8'(i))
                     rdata_nxt = dw_ctl_r[i];
                  if (reg_addr_i == `HBD_IDX_RW_MASK + 8'(i))
                     rdata_nxt = rw_mask_r[i];
                  if (reg_addr_i == `HBD_IDX_RW_VALUE + 8'(i))
                     rdata_nxt = rw_val_r[i];
                  if (reg_addr_i == `HBD_IDX_RW_CTL + 8'(i))
                     rdata_nxt = rw_ctl_r[i];
               end
            end
         endcase
      end
      cfg_rdata_nxt = cfg_scr_rd_i ? scratch_r[cfg_scr_addr_i] : `HBD_RESET_WORD;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mode_r <= HBD_RUN;
         enter_r <= 1'b0;
         stop_out_r <= 8'h00;
         saved_pc_r <= `HBD_RESET_WORD;
         saved_sp_r <= `HBD_RESET_WORD;
         rr_thread_r <= `HBD_RESET_WORD;
         rr_reg_r <= `HBD_RESET_WORD;
         cause_r <= `HBD_RESET_WORD;
         info_r <= `HBD_RESET_WORD;
         stop_mask_r <= `HBD_RESET_WORD;
         rdata_r <= `HBD_RESET_WORD;
         cfg_rdata_r <= `HBD_RESET_WORD;
         for (int i = 0; i < `HBD_NUM_SCR; i++)
            scratch_r[i] <= `HBD_RESET_WORD;
         for (int i = 0; i < NBP; i++)
         begin
            ib_addr_r[i] <= `HBD_RESET_WORD;
            ib_ctl_r[i] <= `HBD_RESET_WORD;
            dw_a_r[i] <= `HBD_RESET_WORD;
            dw_b_r[i] <= `HBD_RESET_WORD;
            dw_ctl_r[i] <= `HBD_RESET_WORD;
            rw_mask_r[i] <= `HBD_RESET_WORD;
            rw_val_r[i] <= `HBD_RESET_WORD;
            rw_ctl_r[i] <= `HBD_RESET_WORD;
         end
      end
      else
      begin
         mode_r <= mode_nxt;
         enter_r <= enter_nxt;
         stop_out_r <= stop_out_nxt;
         saved_pc_r <= saved_pc_nxt;
         saved_sp_r <= saved_sp_nxt;
         rr_thread_r <= rr_thread_nxt;
         rr_reg_r <= rr_reg_nxt;
         cause_r <= cause_nxt;
         info_r <= info_nxt;
         stop_mask_r <= stop_mask_nxt;
         rdata_r <= rdata_nxt;
         cfg_rdata_r <= cfg_rdata_nxt;
         scratch_r <= scratch_nxt;
         ib_addr_r <= ib_addr_nxt;
         ib_ctl_r <= ib_ctl_nxt;
         dw_a_r <= dw_a_nxt;
         dw_b_r <= dw_b_nxt;
         dw_ctl_r <= dw_ctl_nxt;
         rw_mask_r <= rw_mask_nxt;
         rw_val_r <= rw_val_nxt;
         rw_ctl_r <= rw_ctl_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign cfg_scr_rdata_o = cfg_rdata_r;
   assign dbg_mode_o = (mode_r == HBD_DEBUG);
   assign dbg_enter_o = enter_r;
   assign thread_stop_o = stop_out_r;
   assign regread_thread_o = rr_thread_r[7:0];
   assign regread_reg_o = rr_reg_r[4:0];

endmodule : hbd_debug_unit

// >>> hbd_defines.svh
// Register indices, field positions, reset values and codes of the debug unit
`ifndef HBD_DEFINES_SVH
`define HBD_DEFINES_SVH

`define HBD_ADDR_W 8
`define HBD_NUM_BP 4
`define HBD_NUM_THR 8
`define HBD_NUM_SCR 8

`define HBD_IDX_SAVED_PC 8'h11
`define HBD_IDX_SAVED_SP 8'h12
`define HBD_IDX_RR_THREAD 8'h13
`define HBD_IDX_RR_REG 8'h14
`define HBD_IDX_CAUSE 8'h15
`define HBD_IDX_INFO 8'h16
`define HBD_IDX_STOP_MASK 8'h18
`define HBD_IDX_SCRATCH 8'h20
`define HBD_IDX_IB_ADDR 8'h30
`define HBD_IDX_IB_CTL 8'h40
`define HBD_IDX_DW_ADDR_A 8'h50
`define HBD_IDX_DW_ADDR_B 8'h60
`define HBD_IDX_DW_CTL 8'h70
`define HBD_IDX_RW_MASK 8'h80
`define HBD_IDX_RW_VALUE 8'h90
`define HBD_IDX_RW_CTL 8'h9C

`define HBD_RR_THREAD_MASK 32'h0000_00FF
`define HBD_RR_REG_MASK 32'h0000_001F
`define HBD_CAUSE_MASK 32'h0003_FF07
`define HBD_STOP_MASK_MASK 32'h0000_00FF
`define HBD_IB_CTL_MASK 32'h00FF_0003
`define HBD_DW_CTL_MASK 32'h00FF_0007
`define HBD_RW_CTL_MASK 32'h00FF_0003

`define HBD_CTL_EN_BIT 0
`define HBD_CTL_COND_BIT 1
`define HBD_CTL_LOAD_BIT 2
`define HBD_CTL_THR_LSB 16
`define HBD_CAUSE_CODE_LSB 0
`define HBD_CAUSE_THR_LSB 8
`define HBD_CAUSE_IDX_LSB 16

`define HBD_CAUSE_HOST 3'h1
`define HBD_CAUSE_DEBUG_CALL_INSN 3'h2
`define HBD_CAUSE_IBREAK 3'h3
`define HBD_CAUSE_DWATCH 3'h4
`define HBD_CAUSE_RWATCH 3'h5

`define HBD_RESET_WORD 32'h0000_0000

`endif

// >>> hbd_pkg.sv
// Types shared by the debug unit and its users
package hbd_pkg;

   // One observed processor operation (instruction, memory access or resource access)
   typedef struct packed {
      logic valid;
      logic is_load;
      logic [2:0] thread;
      logic [31:0] value;
   } hbd_op_t;

   // Debug entry summary latched into the cause and info registers
   typedef struct packed {
      logic [2:0] code;
      logic [1:0] index;
      logic [7:0] thread;
      logic load_info;
      logic [31:0] info;
   } hbd_entry_t;

   typedef enum logic [0:0] {
      HBD_RUN = 1'b0,
      HBD_DEBUG = 1'b1
   } hbd_mode_t;

endpackage : hbd_pkg

// >>> hbd_cpu_model.sv
// Processor context model: running program counter and stack pointer
`timescale 1ns/10ps
module hbd_cpu_model
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic dbg_mode_i,
   output logic [31:0] ctx_pc_o,
   output logic [31:0] ctx_sp_o
);
   logic [31:0] pc_r;
   logic [31:0] pc_nxt;
   // Context freezes while the debugger owns the tile
   always_comb
   begin
      pc_nxt = dbg_mode_i ? pc_r : pc_r + 32'h0000_0004;
   end
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pc_r <= 32'h0000_1000;
      else
         pc_r <= pc_nxt;
   end
   assign ctx_pc_o = pc_r;
   // Inverted so a swapped capture of the two words is caught
   assign ctx_sp_o = ~pc_r;
endmodule : hbd_cpu_model

// >>> hbd_debug_unit_chk.sv
// Port-level assertions for the debug unit
`timescale 1ns/10ps
module hbd_debug_unit_chk
   import hbd_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire hbd_op_t insn_op_i,
   input wire hbd_op_t mem_op_i,
   input wire hbd_op_t res_op_i,
   input wire logic host_dbg_req_i,
   input wire logic debug_call_insn_i,
   input wire logic dbg_return_i,
   input wire logic dbg_mode_o,
   input wire logic dbg_enter_o,
   input wire logic [7:0] thread_stop_o,
   input wire logic [7:0] regread_thread_o,
   input wire logic [4:0] regread_reg_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rstn_i);
   logic any_ev;
   assign any_ev = host_dbg_req_i | debug_call_insn_i | insn_op_i.valid | mem_op_i.valid
      | res_op_i.valid;
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_entry;
      dbg_mode_o && dbg_enter_o && thread_stop_o == 8'hFF;
   endsequence
   sequence s_held;
      dbg_mode_o && !dbg_enter_o;
   endsequence
   property p_host_entry;
      !dbg_mode_o && host_dbg_req_i |=> s_entry;
   endproperty
   a_host_entry: assert property (p_host_entry)
      else $error("host request did not enter debug mode");
   property p_call_entry;
      !dbg_mode_o && debug_call_insn_i |=> s_entry;
   endproperty
   a_call_entry: assert property (p_call_entry)
      else $error("debug call did not enter debug mode");
   property p_no_cause;
      !dbg_mode_o && !any_ev |=> !dbg_mode_o;
   endproperty
   a_no_cause: assert property (p_no_cause)
      else $error("debug mode entered without a cause");
   property p_stay;
      dbg_mode_o && !dbg_return_i |=> s_held;
   endproperty
   a_stay: assert property (p_stay)
      else $error("debug mode left or re-entered without return");
   property p_stop_dbg;
      dbg_mode_o |-> thread_stop_o == 8'hFF;
   endproperty
   a_stop_dbg: assert property (p_stop_dbg)
      else $error("threads not all stopped in debug mode");
   property p_leave;
      dbg_mode_o && dbg_return_i |=> !dbg_mode_o && !dbg_enter_o;
   endproperty
   a_leave: assert property (p_leave)
      else $error("return did not leave debug mode");
   property p_enter_first;
      dbg_enter_o |-> !$past(dbg_mode_o);
   endproperty
   a_enter_first: assert property (p_enter_first)
      else $error("entry pulse outside first debug cycle");
   property p_sel_hold;
      !dbg_mode_o |=> $stable(regread_thread_o) && $stable(regread_reg_o);
   endproperty
   a_sel_hold: assert property (p_sel_hold)
      else $error("register-read target changed in run mode");
endmodule : hbd_debug_unit_chk

bind hbd_debug_unit hbd_debug_unit_chk u_hbd_debug_unit_chk (.ref_clk_i, .rstn_i, .insn_op_i,
   .mem_op_i, .res_op_i, .host_dbg_req_i, .debug_call_insn_i, .dbg_return_i, .dbg_mode_o,
   .dbg_enter_o, .thread_stop_o, .regread_thread_o, .regread_reg_o);

// >>> hbd_debug_unit_bench.sv
// Self-checking bench for the debug unit
`timescale 1ns/10ps
module hbd_debug_unit_bench
   import hbd_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic [2:0] cfg_scr_addr_i = 3'h0;
   logic [31:0] cfg_scr_wdata_i = 32'h0;
   logic cfg_scr_wr_i = 1'b0;
   logic cfg_scr_rd_i = 1'b0;
   logic [31:0] cfg_scr_rdata_o;
   hbd_op_t insn_op_i = '0;
   hbd_op_t mem_op_i = '0;
   hbd_op_t res_op_i = '0;
   logic host_dbg_req_i = 1'b0;
   logic debug_call_insn_i = 1'b0;
   logic [2:0] debug_call_thread_i = 3'h0;
   logic [31:0] ctx_pc_i;
   logic [31:0] ctx_sp_i;
   logic dbg_return_i = 1'b0;
   logic dbg_mode_o;
   logic dbg_enter_o;
   logic [7:0] thread_stop_o;
   logic [7:0] regread_thread_o;
   logic [4:0] regread_reg_o;
   int errors = 0;
   int cmp_count = 0;
   always #25 ref_clk_i = ~ref_clk_i;
   hbd_debug_unit u_hbd_debug_unit (.ref_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .cfg_scr_addr_i, .cfg_scr_wdata_i, .cfg_scr_wr_i, .cfg_scr_rd_i,
      .cfg_scr_rdata_o, .insn_op_i, .mem_op_i, .res_op_i, .host_dbg_req_i, .debug_call_insn_i,
      .debug_call_thread_i, .ctx_pc_i, .ctx_sp_i, .dbg_return_i, .dbg_mode_o, .dbg_enter_o,
      .thread_stop_o, .regread_thread_o, .regread_reg_o);
   hbd_cpu_model u_hbd_cpu_model (.ref_clk_i, .rstn_i, .dbg_mode_i(dbg_mode_o),
      .ctx_pc_o(ctx_pc_i), .ctx_sp_o(ctx_sp_i));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   function automatic hbd_op_t mk(input logic ld, input logic [2:0] t, input logic [31:0] v);
      mk = '{1'b1, ld, t, v};
   endfunction : mk
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge ref_clk_i);
      chk("reg_rdata_o", e, reg_rdata_o);
   endtask : rd_reg
   task automatic cfg(input logic w, input logic [2:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      cfg_scr_addr_i <= a;
      cfg_scr_wdata_i <= d;
      cfg_scr_wr_i <= w;
      cfg_scr_rd_i <= !w;
      @(posedge ref_clk_i);
      cfg_scr_wr_i <= 1'b0;
      cfg_scr_rd_i <= 1'b0;
      @(negedge ref_clk_i);
      if (!w)
         chk("cfg_scr_rdata_o", d, cfg_scr_rdata_o);
   endtask : cfg
   // Kind: 0 insn, 1 memory, 2 resource, 3 host, else debug call
   task automatic fire(input int k, input hbd_op_t op, input logic e, input logic [31:0] c,
      input logic [31:0] inf);
      logic [31:0] xpc;
      logic [31:0] xsp;
      @(posedge ref_clk_i);
      case (k)
         0: insn_op_i <= op;
         1: mem_op_i <= op;
         2: res_op_i <= op;
         3: host_dbg_req_i <= 1'b1;
         default:
         begin
            debug_call_insn_i <= 1'b1;
            debug_call_thread_i <= op.thread;
         end
      endcase
      @(negedge ref_clk_i);
      xpc = ctx_pc_i;
      xsp = ctx_sp_i;
      @(posedge ref_clk_i);
      insn_op_i <= '0;
      mem_op_i <= '0;
      res_op_i <= '0;
      host_dbg_req_i <= 1'b0;
      debug_call_insn_i <= 1'b0;
      @(negedge ref_clk_i);
      chk("dbg_enter_o", {31'h0, e}, {31'h0, dbg_enter_o});
      if (e)
      begin
         rd_reg(8'h15, c);
         rd_reg(8'h16, inf);
         rd_reg(8'h11, xpc);
         rd_reg(8'h12, xsp);
      end
   endtask : fire
   task automatic leave(input logic [7:0] sm);
      @(posedge ref_clk_i);
      dbg_return_i <= 1'b1;
      @(posedge ref_clk_i);
      dbg_return_i <= 1'b0;
      @(negedge ref_clk_i);
      chk("thread_stop_o", {24'h0, sm}, {24'h0, thread_stop_o});
   endtask : leave
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5000) @(posedge ref_clk_i);
      errors++;
      $display("[FAIL] run time limit expected end seen hang");
      close_out();
   end
   initial
   begin
      repeat (3) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      rd_reg(8'h40, 32'h0);
      rd_reg(8'h70, 32'h0);
      rd_reg(8'h9C, 32'h0);
      // Run-mode writes must be dropped
      wr_reg(8'h18, 32'h0000_00FF);
      rd_reg(8'h18, 32'h0);
      fire(3, mk(0, 3'h0, 32'h0), 1'b1, 32'h0000_0001, 32'h0);
      wr_reg(8'h13, 32'hFFFF_FFFF);
      wr_reg(8'h14, 32'hFFFF_FFFF);
      rd_reg(8'h13, 32'h0000_00FF);
      rd_reg(8'h14, 32'h0000_001F);
      chk("regread_thread_o", 32'hFF, {24'h0, regread_thread_o});
      chk("regread_reg_o", 32'h1F, {27'h0, regread_reg_o});
      wr_reg(8'hA0, 32'h1234_5678);
      rd_reg(8'hA0, 32'h0);
      for (int i = 0; i < 8; i++)
         wr_reg(8'h20 + 8'(i), 32'hA000_0000 + 32'(i));
      for (int i = 0; i < 8; i++)
         cfg(1'b0, 3'(i), 32'hA000_0000 + 32'(i));
      cfg(1'b1, 3'h3, 32'h5A5A_0003);
      rd_reg(8'h23, 32'h5A5A_0003);
      wr_reg(8'h18, 32'h0000_0005);
      wr_reg(8'h31, 32'h0000_0100);
      wr_reg(8'h41, 32'h0002_0001);
      wr_reg(8'h32, 32'h0000_0200);
      wr_reg(8'h42, 32'hFF02_FFFF);
      rd_reg(8'h42, 32'h0002_0003);
      leave(8'h05);
      fire(0, mk(0, 3'h3, 32'h100), 1'b0, 32'h0, 32'h0);
      fire(0, mk(0, 3'h1, 32'h200), 1'b0, 32'h0, 32'h0);
      fire(0, mk(0, 3'h1, 32'h100), 1'b1, 32'h0001_0103, 32'h0);
      wr_reg(8'h41, 32'h0);
      wr_reg(8'h42, 32'h0);
      wr_reg(8'h53, 32'h0000_1000);
      wr_reg(8'h63, 32'h0000_10FF);
      wr_reg(8'h73, 32'h0040_0001);
      leave(8'h05);
      fire(1, mk(0, 3'h6, 32'h2000), 1'b0, 32'h0, 32'h0);
      fire(1, mk(1, 3'h6, 32'h1010), 1'b0, 32'h0, 32'h0);
      fire(1, mk(0, 3'h6, 32'h1010), 1'b1, 32'h0003_0604, 32'h1010);
      wr_reg(8'h73, 32'h0040_0007);
      leave(8'h05);
      fire(1, mk(1, 3'h6, 32'h3000), 1'b1, 32'h0003_0604, 32'h3000);
      wr_reg(8'h73, 32'h0);
      wr_reg(8'h81, 32'h0000_00FF);
      wr_reg(8'h91, 32'h0000_0042);
      wr_reg(8'h9D, 32'h0080_0001);
      leave(8'h05);
      fire(2, mk(0, 3'h7, 32'h1142), 1'b1, 32'h0001_0705, 32'h1142);
      wr_reg(8'h9D, 32'h0080_0003);
      leave(8'h05);
      fire(2, mk(0, 3'h7, 32'h0042), 1'b0, 32'h0, 32'h0);
      fire(2, mk(0, 3'h7, 32'h0043), 1'b1, 32'h0001_0705, 32'h0043);
      wr_reg(8'h9D, 32'h0);
      leave(8'h05);
      fire(4, mk(0, 3'h5, 32'h0), 1'b1, 32'h0000_0502, 32'h0043);
      leave(8'h05);
      fire(0, mk(0, 3'h1, 32'h100), 1'b0, 32'h0, 32'h0);
      close_out();
   end
endmodule : hbd_debug_unit_bench
